// ### hw/stc_pkg.sv
// constants and types for the transparent serial channel
package stc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned FIFO_FILL_NS = 1000;
   localparam int unsigned FILL_CYC = (FIFO_FILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_EVENT = 8'h08;
   localparam logic [7:0] OFS_EMASK = 8'h0C;
   localparam logic [7:0] OFS_PASEL = 8'h10;
   localparam logic [7:0] OFS_SERIAL_INTERFACE_MODE_REG = 8'h14;
   localparam logic [7:0] OFS_SLOTMASK = 8'h18;
   localparam logic [7:0] OFS_SYNCPAT = 8'h1C;
   localparam logic [7:0] OFS_MAX_RECEIVE_BUFFER_LENGTH = 8'h20;
   localparam logic [7:0] OFS_TXBD = 8'h24;
   localparam logic [7:0] OFS_RXBD = 8'h28;
   localparam logic [1:0] MEM_TX = 2'h1;
   localparam logic [1:0] MEM_RX = 2'h2;
   localparam int unsigned EV_RX = 0;
   localparam int unsigned EV_TX = 1;
   localparam int unsigned EV_BSY = 2;
   localparam int unsigned EV_RCH = 4;
   localparam int unsigned ST_CD = 0;
   localparam int unsigned ST_CTS = 1;
   localparam int unsigned ST_IDLE = 2;
   localparam int unsigned BD_READY = 0;
   localparam int unsigned BD_INTR = 1;
   localparam int unsigned BD_LAST = 2;
   localparam int unsigned BD_LEN_LSB = 8;
   localparam int unsigned PA_TXD = 0;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] SERIAL_INTERFACE_MODE_REG_RST = 8'h00;
   localparam logic [15:0] PASEL_RST = 16'h0000;
   localparam logic [15:0] SYNCPAT_RST = 16'h7E7E;
   localparam logic [15:0] MAX_RECEIVE_BUFFER_LENGTH_RST = 16'h0010;
   localparam logic [1:0] PHY_DED = 2'h0;
   localparam logic [1:0] PHY_HWY = 2'h1;
   localparam logic [1:0] PHY_ISDN = 2'h2;
   localparam logic [1:0] DIAG_LOOP = 2'h1;
   localparam logic [3:0] SLOT_BITS = 4'h8;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   typedef struct packed {
      logic ext_sync;
      logic transparent_select;
      logic [1:0] protocol;
      logic [1:0] diagnostic_mode_field;
      logic receiver_enable;
      logic transmitter_enable;
   } stc_mode_s;
   typedef struct packed {
      logic [2:0] spare;
      logic [1:0] bchan_sel;
      logic one_clock_prior;
      logic [1:0] phy;
   } stc_serial_interface_mode_reg_s;
   typedef struct packed {
      logic highway_serial_clock;
      logic [1:0] slot_sync_pair;
      logic rxd;
      logic cd_n;
      logic cts_n;
   } stc_link_s;
   typedef enum logic [2:0] {TX_IDLE, TX_FILL, TX_WAIT, TX_DATA} stc_tx_e;
endpackage

// ### hw/stc_channel.sv
// transparent serial channel with avalon-mm register slave
`timescale 1ns/1ps
module stc_channel #(
   parameter int unsigned TX_DEPTH = 16,
   parameter int unsigned RX_WORDS = 8,
   parameter logic [1:0] CHAN_CODE = 2'h1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire stc_pkg::stc_link_s link_in,
   output logic txd_o,
   output logic txd_oe,
   output logic rts_n,
   output logic chan_irq_req,
   output logic [15:0] pin_func_sel
);
   import stc_pkg::*;
   localparam int unsigned TXAW = $clog2(TX_DEPTH);
   localparam int unsigned RXAW = $clog2(RX_WORDS);

   // memories are addressed by a 4-bit word index, so depths stay powers of two up to 16
   if (TX_DEPTH < 2 || TX_DEPTH > 16 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_chk_tx
      $error("TX_DEPTH must be a power of two from 2 to 16");
   end
   if (RX_WORDS < 2 || RX_WORDS > 16 || (RX_WORDS & (RX_WORDS - 1)) != 0) begin : g_chk_rx
      $error("RX_WORDS must be a power of two from 2 to 16");
   end

   stc_link_s lk1_r, lk2_r;
   logic sclk_d_r, sel_prev_r, fs_prev_r;
   logic [3:0] ocp_cnt_r;
   logic [5:0] pos_r, pos_now;
   stc_mode_s mode_r;
   stc_serial_interface_mode_reg_s serial_interface_mode_reg_r;
   logic [15:0] pasel_r, slotmask_r, syncpat_r, max_receive_buffer_length_r;
   logic [7:0] ev_r, emask_r, ev_set;
   logic [15:0] txbd_r;
   logic rx_empty_r, rx_intr_r, tx_last_r;
   logic [7:0] tx_mem [TX_DEPTH];
   logic [15:0] rx_mem [RX_WORDS];
   stc_tx_e tx_state_r;
   logic [7:0] tx_shift_r, tx_idx_r, tx_eff_idx, tx_len;
   logic [2:0] tx_bit_r;
   logic [7:0] fill_r;
   logic tx_done_r, tx_chain, tx_load, tx_complete, tx_on;
   logic sclk_rise, hw_sel, gate, slot_start, tick;
   logic rx_on, rx_armed_r, rx_take, rx_in, word_done, rx_full_now;
   logic [15:0] rx_shift_r, rx_word, rx_bytes_nxt;
   logic [3:0] rx_bit_r;
   logic [RXAW:0] rx_widx_r;
   logic rd_ack_r, wr_en;
   logic [31:0] rd_mux;
   logic [3:0] widx;
   logic [2:0] status;

   // two flops on every link pin; the edge finder reads only the second
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lk1_r <= '0;
         lk2_r <= '0;
         sclk_d_r <= 1'b0;
      end else if (ce) begin
         lk1_r <= link_in;
         lk2_r <= lk1_r;
         sclk_d_r <= lk2_r.highway_serial_clock;
      end
   end

   assign sclk_rise = lk2_r.highway_serial_clock & ~sclk_d_r;
   assign hw_sel = (lk2_r.slot_sync_pair == CHAN_CODE);
   // isdn frame sync rides on the low sync pin; bit position restarts at its rise
   assign pos_now = (lk2_r.slot_sync_pair[0] & ~fs_prev_r) ? 6'h00 :
                    (pos_r == 6'h3F) ? pos_r : pos_r + 6'h01;

   // slot tracking per serial clock edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sel_prev_r <= 1'b0;
         fs_prev_r <= 1'b0;
         ocp_cnt_r <= '0;
         pos_r <= 6'h3F;
      end else if (ce && sclk_rise) begin
         sel_prev_r <= hw_sel;
         fs_prev_r <= lk2_r.slot_sync_pair[0];
         pos_r <= pos_now;
         if (hw_sel && !sel_prev_r) begin
            ocp_cnt_r <= SLOT_BITS; // slot follows the one-clock pulse
         end else if (ocp_cnt_r != 4'h0) begin
            ocp_cnt_r <= ocp_cnt_r - 4'h1;
         end
      end
   end

   // clock gate and slot-start marker for the selected physical interface
   always_comb begin
      gate = 1'b1;
      slot_start = 1'b1;
      unique case (serial_interface_mode_reg_r.phy)
         PHY_HWY: begin
            if (serial_interface_mode_reg_r.one_clock_prior) begin
               gate = (ocp_cnt_r != 4'h0);
               slot_start = (ocp_cnt_r == SLOT_BITS);
            end else begin
               gate = hw_sel; // envelope spans the whole slot
               slot_start = hw_sel & ~sel_prev_r;
            end
         end
         PHY_ISDN: begin
            // either b-channel, both, or masked bits of them
            gate = (pos_now < 6'd16) && slotmask_r[pos_now[3:0]] &&
                   (pos_now[3] ? serial_interface_mode_reg_r.bchan_sel[1] : serial_interface_mode_reg_r.bchan_sel[0]);
            // external sync aligns to a b-channel's first bit
            slot_start = !mode_r.ext_sync ||
                         (pos_now == 6'd0 && serial_interface_mode_reg_r.bchan_sel[0]) ||
                         (pos_now == 6'd8 && serial_interface_mode_reg_r.bchan_sel[1]);
         end
         default: begin
            gate = 1'b1; // dedicated pins clock every edge
            slot_start = 1'b1;
         end
      endcase
   end

   assign tick = ce & sclk_rise & gate;
   // transparent select overrides the protocol field
   assign tx_on = mode_r.transmitter_enable & mode_r.transparent_select;
   assign rx_on = mode_r.receiver_enable & mode_r.transparent_select;
   assign tx_len = txbd_r[BD_LEN_LSB +: 8];
   // a ready follow-on descriptor after a non-last one chains with no gap
   assign tx_chain = tx_done_r & txbd_r[BD_READY] & ~tx_last_r;
   assign tx_eff_idx = tx_done_r ? 8'h00 : tx_idx_r;
   assign tx_load = tick && tx_state_r == TX_DATA && tx_bit_r == 3'd7 &&
                    (!tx_done_r || tx_chain);
   // length is limited by the descriptor only
   assign tx_complete = tx_load && ({1'b0, tx_eff_idx} + 9'd1 >= {1'b0, tx_len});

   // transmit sequencer: fill, wait for slot, lead byte, data
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= IDLE_BYTE;
         tx_bit_r <= '0;
         tx_idx_r <= '0;
         tx_done_r <= 1'b0;
         tx_last_r <= 1'b0;
         fill_r <= '0;
      end else if (ce) begin
         if (!tx_on) begin
            // dropping enable, like a halt to idle, re-aligns the byte phase
            tx_state_r <= TX_IDLE;
            tx_shift_r <= IDLE_BYTE;
            tx_bit_r <= '0;
         end else begin
            unique case (tx_state_r)
               TX_IDLE: begin
                  if (txbd_r[BD_READY]) begin
                     tx_state_r <= TX_FILL;
                     fill_r <= '0;
                  end
               end
               TX_FILL: begin
                  // data waits until the fifo has had time to fill
                  if (fill_r == 8'(FILL_CYC - 1)) begin
                     tx_state_r <= TX_WAIT;
                  end else begin
                     fill_r <= fill_r + 8'h01;
                  end
               end
               TX_WAIT: begin
                  if (tick && slot_start) begin
                     // this slot opens with one all-ones lead byte
                     tx_state_r <= TX_DATA;
                     tx_shift_r <= IDLE_BYTE;
                     tx_bit_r <= 3'd0; // the slot-start tick already shows bit 0 of the lead byte
                     tx_idx_r <= '0;
                     tx_done_r <= 1'b0;
                  end
               end
               TX_DATA: begin
                  if (tick) begin
                     if (tx_bit_r != 3'd7) begin
                        tx_shift_r <= {tx_shift_r[6:0], 1'b1};
                        tx_bit_r <= tx_bit_r + 3'd1;
                     end else if (tx_load) begin
                        tx_shift_r <= tx_mem[tx_eff_idx[TXAW-1:0]];
                        tx_bit_r <= '0;
                        tx_idx_r <= tx_eff_idx + 8'h01;
                        tx_done_r <= tx_complete;
                        if (tx_complete) begin
                           tx_last_r <= txbd_r[BD_LAST];
                        end
                     end else begin
                        // last descriptor done or next one not ready: halt with idle ones
                        tx_state_r <= TX_IDLE;
                        tx_shift_r <= IDLE_BYTE;
                        tx_bit_r <= '0;
                     end
                  end
               end
               default: tx_state_r <= TX_IDLE;
            endcase
         end
      end
   end

   assign rts_n = ~(tx_state_r == TX_WAIT || tx_state_r == TX_DATA);
   assign txd_o = tx_shift_r[7];
   // on dedicated pins the port a select hands the data pin over
   assign txd_oe = (serial_interface_mode_reg_r.phy == PHY_DED) ? pasel_r[PA_TXD] : (gate & tx_on);
   assign pin_func_sel = pasel_r;

   // loopback feeds the transmit bit straight back; other codes are alike
   assign rx_in = (mode_r.diagnostic_mode_field == DIAG_LOOP) ? tx_shift_r[7] : lk2_r.rxd;
   assign rx_take = tick & rx_on & (rx_armed_r | slot_start | ~mode_r.ext_sync);
   assign word_done = rx_take & (rx_bit_r == 4'hF);
   assign rx_word = {rx_shift_r[14:0], rx_in};
   assign rx_bytes_nxt = 16'({rx_widx_r, 1'b0}) + 16'h0002;
   // buffer closes at the receive length limit or at the end of store
   assign rx_full_now = word_done & rx_empty_r &
                        ((rx_bytes_nxt >= max_receive_buffer_length_r) || (rx_widx_r == (RXAW + 1)'(RX_WORDS - 1)));

   // receive shifter; with ext_sync set, reception begins at the first slot after enable
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_armed_r <= 1'b0;
         rx_shift_r <= '0;
         rx_bit_r <= '0;
      end else if (ce) begin
         if (!rx_on) begin
            rx_armed_r <= 1'b0;
            rx_bit_r <= '0;
         end else if (rx_take) begin
            rx_armed_r <= 1'b1;
            rx_shift_r <= rx_word;
            rx_bit_r <= rx_bit_r + 4'h1;
         end
      end
   end

   // event sources
   always_comb begin
      ev_set = '0;
      ev_set[EV_TX] = tx_complete & txbd_r[BD_INTR];
      ev_set[EV_RX] = rx_full_now & rx_intr_r;
      ev_set[EV_BSY] = word_done & ~rx_empty_r;
      ev_set[EV_RCH] = word_done & rx_empty_r;
   end

   assign wr_en = ce & avs_write;
   assign widx = avs_address[5:2];

   // control registers; software writes win over the hardware clears
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= MODE_RST;
         serial_interface_mode_reg_r <= SERIAL_INTERFACE_MODE_REG_RST;
         pasel_r <= PASEL_RST;
         slotmask_r <= '0;
         syncpat_r <= SYNCPAT_RST;
         max_receive_buffer_length_r <= MAX_RECEIVE_BUFFER_LENGTH_RST;
         emask_r <= '0;
         txbd_r <= '0;
         rx_empty_r <= 1'b0;
         rx_intr_r <= 1'b0;
         rx_widx_r <= '0;
      end else if (ce) begin
         if (tx_complete) begin
            txbd_r[BD_READY] <= 1'b0;
         end
         if (word_done && rx_empty_r) begin
            rx_widx_r <= rx_widx_r + (RXAW + 1)'(1);
         end
         if (rx_full_now) begin
            rx_empty_r <= 1'b0;
         end
         if (wr_en) begin
            unique case (avs_address)
               OFS_MODE: mode_r <= avs_writedata[7:0];
               OFS_SERIAL_INTERFACE_MODE_REG: serial_interface_mode_reg_r <= avs_writedata[7:0];
               OFS_PASEL: pasel_r <= avs_writedata[15:0];
               OFS_SLOTMASK: slotmask_r <= avs_writedata[15:0];
               OFS_SYNCPAT: syncpat_r <= avs_writedata[15:0]; // kept, never used
               OFS_MAX_RECEIVE_BUFFER_LENGTH: max_receive_buffer_length_r <= avs_writedata[15:0];
               OFS_EMASK: emask_r <= avs_writedata[7:0];
               OFS_TXBD: txbd_r <= avs_writedata[15:0];
               OFS_RXBD: begin
                  rx_empty_r <= avs_writedata[0];
                  rx_intr_r <= avs_writedata[1];
                  if (avs_writedata[0]) begin
                     rx_widx_r <= '0;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // event register: hardware sets win over write-one clears
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ev_r <= '0;
      end else if (ce) begin
         if (wr_en && avs_address == OFS_EVENT) begin
            ev_r <= (ev_r & ~avs_writedata[7:0]) | ev_set;
         end else begin
            ev_r <= ev_r | ev_set; // recorded even when masked
         end
      end
   end

   // the mask only gates the request line
   assign chan_irq_req = |(ev_r & emask_r);

   // buffer memories: software fills transmit data, hardware stores receive words
   always_ff @(posedge core_clk) begin
      if (wr_en && avs_address[7:6] == MEM_TX && 32'(widx) < TX_DEPTH) begin
         tx_mem[widx[TXAW-1:0]] <= avs_writedata[7:0];
      end
      if (ce && word_done && rx_empty_r) begin
         rx_mem[rx_widx_r[RXAW-1:0]] <= rx_word;
      end
   end

   // status: carrier and cts forced low on highway while enabled
   always_comb begin
      status = '0;
      status[ST_CD] = (serial_interface_mode_reg_r.phy == PHY_HWY && mode_r.receiver_enable) ?
                      1'b0 : lk2_r.cd_n;
      status[ST_CTS] = (serial_interface_mode_reg_r.phy == PHY_HWY && mode_r.transmitter_enable) ?
                       1'b0 : lk2_r.cts_n;
      status[ST_IDLE] = 1'b0; // meaningless in transparent mode
   end

   // read decode; unmapped words read zero
   always_comb begin
      rd_mux = '0;
      unique case (avs_address[7:6])
         MEM_TX: if (32'(widx) < TX_DEPTH) rd_mux[7:0] = tx_mem[widx[TXAW-1:0]];
         MEM_RX: if (32'(widx) < RX_WORDS) rd_mux[15:0] = rx_mem[widx[RXAW-1:0]];
         default: begin
            unique case (avs_address)
               OFS_MODE: rd_mux[7:0] = mode_r;
               OFS_STATUS: rd_mux[2:0] = status;
               OFS_EVENT: rd_mux[7:0] = ev_r;
               OFS_EMASK: rd_mux[7:0] = emask_r;
               OFS_PASEL: rd_mux[15:0] = pasel_r;
               OFS_SERIAL_INTERFACE_MODE_REG: rd_mux[7:0] = serial_interface_mode_reg_r;
               OFS_SLOTMASK: rd_mux[15:0] = slotmask_r;
               OFS_SYNCPAT: rd_mux[15:0] = syncpat_r;
               OFS_MAX_RECEIVE_BUFFER_LENGTH: rd_mux[15:0] = max_receive_buffer_length_r;
               OFS_TXBD: rd_mux[15:0] = txbd_r;
               OFS_RXBD: rd_mux[15:0] = {8'(rx_widx_r), 6'h00, rx_intr_r, rx_empty_r};
               default: rd_mux = '0;
            endcase
         end
      endcase
   end

   // reads take one wait cycle so the data come from a flop
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ack_r <= 1'b0;
         avs_readdata <= '0;
      end else if (ce) begin
         rd_ack_r <= avs_read & ~rd_ack_r;
         if (avs_read && !rd_ack_r) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   assign avs_waitrequest = avs_read & ~rd_ack_r;

   // checks
   a_hwy_status_low: assert property (@(posedge core_clk) disable iff (!rstn)
      serial_interface_mode_reg_r.phy == PHY_HWY && mode_r.receiver_enable |-> !status[ST_CD])
      else $error("carrier bit not low on highway");
   a_idle_bit_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !rd_ack_r && avs_address == OFS_STATUS |=> !avs_readdata[ST_IDLE])
      else $error("idle bit read as one");
   a_idle_all_ones: assert property (@(posedge core_clk) disable iff (!rstn)
      tx_state_r != TX_DATA |=> tx_state_r == TX_DATA || tx_shift_r == IDLE_BYTE)
      else $error("non-idle bits while not sending");
   a_isdn_b_start: assert property (@(posedge core_clk) disable iff (!rstn)
      tx_state_r == TX_WAIT ##1 tx_state_r == TX_DATA |->
      $past(slot_start) && $past(tick))
      else $error("data started off a slot boundary");
   a_event_w1c: assert property (@(posedge core_clk) disable iff (!rstn)
      ce && avs_write && avs_address == OFS_EVENT && avs_writedata[7:0] == 8'hFF
      && ev_set == 8'h00 |=> ev_r == 8'h00)
      else $error("event not cleared by write of ones");
   a_mask_gates_req: assert property (@(posedge core_clk) disable iff (!rstn)
      emask_r == 8'h00 |-> !chan_irq_req)
      else $error("masked event reached request");
   a_tx_event_set: assert property (@(posedge core_clk) disable iff (!rstn)
      tx_complete && txbd_r[BD_INTR] |=> ev_r[EV_TX] && !txbd_r[BD_READY] || $past(wr_en))
      else $error("tx completion not recorded");
   a_busy_on_discard: assert property (@(posedge core_clk) disable iff (!rstn)
      word_done && !rx_empty_r |=> ev_r[EV_BSY])
      else $error("discarded word without busy event");
   a_loop_internal: assert property (@(posedge core_clk) disable iff (!rstn)
      rx_take && mode_r.diagnostic_mode_field == DIAG_LOOP |=> rx_shift_r[0] == $past(txd_o))
      else $error("loopback bit mismatch");
   a_shift_holds: assert property (@(posedge core_clk) disable iff (!rstn)
      tx_on && !tick && tx_state_r == TX_DATA |=> $stable(tx_shift_r))
      else $error("shifter moved without gated clock");
   c_lead_then_data: cover property (@(posedge core_clk) disable iff (!rstn)
      tx_state_r == TX_WAIT ##1 tx_state_r == TX_DATA);
   c_chain_bd: cover property (@(posedge core_clk) disable iff (!rstn) tx_load && tx_chain);
   c_rx_full: cover property (@(posedge core_clk) disable iff (!rstn) rx_full_now);
   c_busy: cover property (@(posedge core_clk) disable iff (!rstn) ev_set[EV_BSY]);
endmodule

// ### testbench/stc_link_model.sv
// highway far side: free-running serial clock, envelope sync, byte capture
`timescale 1ns/1ps
module stc_link_model
   import stc_pkg::*;
(
   input wire logic txd,
   output stc_link_s link
);
   logic [7:0] got [0:63];
   logic [7:0] sh = 8'hFF;
   logic clk = 1'b0;
   logic on = 1'b0;
   int n = 0;
   // rxd returns the inverse of txd inside the slot and txd itself outside it;
   // status pins idle high so that forced-low status bits can be told apart
   assign link = '{highway_serial_clock: clk, slot_sync_pair: on ? 2'h1 : 2'h0,
      rxd: on ? ~txd : txd, cd_n: 1'b1, cts_n: 1'b1};
   // 16-bit frame: 8-bit slot for this channel, then 8 idle bits
   initial begin
      forever for (int i = 0; i < 16; i++) begin
         on = (i < 8); // sync spans the slot
         #100 clk = 1'b1;
         #400 clk = 1'b0;
         #300 sh = {sh[6:0], txd};
         if (i == 7) begin
            got[n % 64] = sh;
            n++;
         end
      end
   end
endmodule

// ### testbench/stc_channel_tb.sv
// self-checking bench for the transparent serial channel
`timescale 1ns/1ps
module stc_channel_tb;
   import stc_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] q;
   logic avs_waitrequest, txd_o, txd_oe, rts_n, chan_irq_req;
   logic [15:0] pin_func_sel;
   stc_link_s link_in;
   int fails = 0;
   int check_count = 0;
   int k, n0;
   stc_channel u_stc_channel (.core_clk(core_clk), .rstn(rstn), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link_in(link_in), .txd_o(txd_o),
      .txd_oe(txd_oe), .rts_n(rts_n), .chan_irq_req(chan_irq_req),
      .pin_func_sel(pin_func_sel));
   stc_link_model u_stc_link_model (.txd(txd_o), .link(link_in));
   // 10 MHz system clock
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   // one bus cycle; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a hang counts as a mismatch; tests need well under 10000 cycles
   initial begin
      #4000000;
      fails++;
      print_verdict;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, OFS_SYNCPAT, 32'h0);
      chk("syncpat", {16'h0, SYNCPAT_RST}, q);
      bus(1'b0, OFS_SERIAL_INTERFACE_MODE_REG, 32'h0);
      chk("serial_interface_mode_reg", {24'h0, SERIAL_INTERFACE_MODE_REG_RST}, q);
      bus(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, OFS_PASEL, 32'h1);
      chk("pin_func_sel", 32'h1, {16'h0, pin_func_sel});
      chk("txd_oe", 32'h1, {31'h0, txd_oe});
      $display("test reset_and_pins done");
      // configure everything, enables go last
      bus(1'b1, OFS_SERIAL_INTERFACE_MODE_REG, {30'h0, PHY_HWY});
      bus(1'b1, OFS_EMASK, 32'h0);
      bus(1'b1, OFS_RXBD, 32'h3);
      bus(1'b1, 8'h40, 32'hA5);
      bus(1'b1, 8'h44, 32'h3C);
      bus(1'b1, OFS_TXBD, 32'h0207);
      bus(1'b1, OFS_EVENT, 32'hFF);
      n0 = u_stc_link_model.n;
      bus(1'b1, OFS_MODE, 32'hF3);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h0, q);
      for (k = 0; k < 100 && rts_n !== 1'b0; k++) @(posedge core_clk);
      chk("rts_n", 32'h0, {31'h0, rts_n});
      k = 0;
      do bus(1'b0, OFS_EVENT, 32'h0); while (q[EV_TX] !== 1'b1 && ++k < 400);
      chk("tx event", 32'h1, {31'h0, q[EV_TX]});
      chk("irq masked", 32'h0, {31'h0, chan_irq_req});
      bus(1'b1, OFS_EMASK, 32'h1 << EV_TX);
      chk("irq unmasked", 32'h1, {31'h0, chan_irq_req});
      bus(1'b1, OFS_EVENT, 32'h1 << EV_TX);
      bus(1'b0, OFS_EVENT, 32'h0);
      chk("tx event cleared", 32'h0, {31'h0, q[EV_TX]});
      bus(1'b0, OFS_TXBD, 32'h0);
      chk("txbd ready", 32'h0, {31'h0, q[BD_READY]});
      repeat (400) @(posedge core_clk);
      for (k = n0; k < u_stc_link_model.n - 3 && u_stc_link_model.got[k] === 8'hFF; k++);
      chk("lead byte", 32'hFF, {24'h0, u_stc_link_model.got[k - 1]});
      chk("byte0", 32'hA5, {24'h0, u_stc_link_model.got[k]});
      chk("byte1", 32'h3C, {24'h0, u_stc_link_model.got[k + 1]});
      chk("idle after", 32'hFF, {24'h0, u_stc_link_model.got[k + 2]});
      $display("test highway_transmit done");
      k = 0;
      do bus(1'b0, OFS_EVENT, 32'h0); while (q[EV_BSY] !== 1'b1 && ++k < 2000);
      chk("rx event", 32'h1, {31'h0, q[EV_RX]});
      chk("busy event", 32'h1, {31'h0, q[EV_BSY]});
      chk("word event", 32'h1, {31'h0, q[EV_RCH]});
      bus(1'b0, OFS_RXBD, 32'h0);
      chk("rxbd", 32'h0802, {16'h0, q[15:0]});
      $display("test receive done");
      // one word for each of diagnostic codes 0 to 2, tx idle: loopback sees ones, the line their inverse
      for (int d = 0; d < 3; d++) begin
         bus(1'b1, OFS_MODE, 32'h0);
         bus(1'b1, OFS_EVENT, 32'hFF);
         bus(1'b1, OFS_RXBD, 32'h1);
         bus(1'b1, OFS_MODE, 32'hC2 | (d << 2));
         k = 0;
         do bus(1'b0, OFS_EVENT, 32'h0); while (q[EV_RCH] !== 1'b1 && ++k < 400);
         bus(1'b0, 8'h80, 32'h0);
         chk("rx word0", (d == 1) ? 32'hFFFF : 32'h0, q);
      end
      $display("test diagnostic_modes done");
      print_verdict;
   end
endmodule
